// >>> sim/bdc_config_space_properties.sv
// Purpose: bus and cache mode properties of the block config space
// Assumes: zero wait state slave, ce high during traffic
// Notes:   read data judged one edge after its address phase
`timescale 1ns/100ps
module bdc_config_space_chk #(
  parameter logic [63:0] CAPACITY_SECTORS = 64'h0000_0000_0010_0000,
  parameter logic [15:0] QUEUE_COUNT      = 16'h0004,
  parameter logic [31:0] OFFER            = bdc_pkg::FEAT_ALL
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] activeQueues,
  input wire logic        writesFail,
  input wire logic        cacheWriteback,
  input wire logic        flushOffered,
  input wire logic        driverReady
);
  logic rdTake;
  logic wrModeQ;
  logic [63:0] cap;
  assign cap = CAPACITY_SECTORS;
  assign rdTake = hsel && htrans[1] && hready && ce && !hwrite;
  // only cache field and status writes may move the mode
  always_ff @(posedge clk) wrModeQ <= hsel && htrans[1] && hready && ce && hwrite &&
    (haddr[7:2] == bdc_pkg::OFF_CACHE_QC[7:2] || haddr[7:2] == bdc_pkg::OFF_STATUS[7:2]);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_queues; activeQueues == 16'h0001 || activeQueues == QUEUE_COUNT; endproperty
  a_queues: assert property (p_queues) else $error("queue count out of range");
  property p_rofail; writesFail == OFFER[bdc_pkg::FEAT_READ_ONLY]; endproperty
  a_rofail: assert property (p_rofail) else $error("write fail flag wrong");
  property p_flush; flushOffered || !OFFER[bdc_pkg::FEAT_CACHE_MODE_CTRL]; endproperty
  a_flush: assert property (p_flush) else $error("flush not offered");
  property p_capacity; rdTake && haddr[7:2] == 6'h00 |=> hrdata == cap[31:0] ||
    hrdata == {cap[39:32], cap[47:40], cap[55:48], cap[63:56]}; endproperty
  a_capacity: assert property (p_capacity) else $error("capacity word wrong");
  property p_pad; rdTake && haddr[7:2] == 6'h08 |=> hrdata[15:1] == 15'h0000; endproperty
  a_pad: assert property (p_pad) else $error("pad byte not zero");
  property p_qfield; OFFER[bdc_pkg::FEAT_MULTIQUEUE] && rdTake && haddr[7:2] == 6'h08 |=>
    hrdata[31:16] == QUEUE_COUNT || hrdata[31:16] == {QUEUE_COUNT[7:0], QUEUE_COUNT[15:8]};
  endproperty
  a_qfield: assert property (p_qfield) else $error("queue field wrong");
  property p_tailpad; rdTake && haddr[7:2] == 6'h0E |=> hrdata[31:8] == 24'h00_0000; endproperty
  a_tailpad: assert property (p_tailpad) else $error("tail pad not zero");
  property p_mode; $changed(cacheWriteback) |-> $past(wrModeQ); endproperty
  a_mode: assert property (p_mode) else $error("mode moved without write");
  property p_ready; $rose(driverReady) |-> $past(wrModeQ); endproperty
  a_ready: assert property (p_ready) else $error("ready without status write");
  property p_field; rdTake && haddr[7:2] == 6'h08 |=> hrdata[0] == $past(cacheWriteback);
  endproperty
  a_field: assert property (p_field) else $error("cache field differs");
  c_cache_read: cover property (rdTake && haddr[7:2] == 6'h08);
  c_mode_up: cover property ($rose(cacheWriteback));
  c_ready: cover property ($rose(driverReady));
endmodule

bind bdc_config_space bdc_config_space_chk #(.CAPACITY_SECTORS(CAPACITY_SECTORS),
  .QUEUE_COUNT(QUEUE_COUNT), .OFFER(OFFER)) u_chk (.clk(clk), .nrst(nrst), .ce(ce),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .activeQueues(activeQueues), .writesFail(writesFail), .cacheWriteback(cacheWriteback),
  .flushOffered(flushOffered), .driverReady(driverReady));

// >>> sim/tb_top.sv
// Purpose: directed bench for the block config space
// Assumes: ce high except in the stall scenario, one idle cycle between transfers
// Notes:   expectations follow the local parameter values below
`timescale 1ns/100ps
module tb_top;
  localparam logic [63:0] CAP = 64'h0123_4567_89AB_CDEF;
  localparam logic [15:0] QC  = 16'h0006;
  localparam logic [31:0] DSC = 32'h0000_1234;
  localparam logic [31:0] ZFS = 32'h0000_5678;
  logic        clk, nrst, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic        writesFail, cacheWriteback, flushOffered, driverReady;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [15:0] activeQueues;
  int          n_fail, comparisons;
  assign hready = hreadyout;
  bdc_config_space #(.CAPACITY_SECTORS(CAP), .QUEUE_COUNT(QC), .DISCARD_SECTORS(DSC),
    .ZF_SECTORS(ZFS)) dut (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .activeQueues(activeQueues),
    .writesFail(writesFail), .cacheWriteback(cacheWriteback), .flushOffered(flushOffered),
    .driverReady(driverReady));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] bsw(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rv, e);
  endtask
  // output sampled mid cycle so the update edge has landed
  task automatic mode(input logic e);
    @(negedge clk);
    chk({31'h0, cacheWriteback}, {31'h0, e});
  endtask
  task automatic t_reset;
    @(negedge clk);
    chk({31'h0, cacheWriteback}, 32'h0000_0001);
    chk({16'h0, activeQueues}, 32'h0000_0001);
    chk({31'h0, writesFail}, 32'h0000_0001);
    chk({31'h0, flushOffered}, 32'h0000_0001);
    chk({30'h0, driverReady, hresp}, 32'h0000_0000);
  endtask
  task automatic t_map;
    rd(bdc_pkg::OFF_CAP_LO, CAP[31:0]);
    rd(bdc_pkg::OFF_CAP_HI, CAP[63:32]);
    rd(bdc_pkg::OFF_DEV_FEAT, bdc_pkg::FEAT_ALL);
    // cache field read only after acceptance; nothing negotiated, so no flush
    wr(bdc_pkg::OFF_STATUS, 32'h0000_0008);
    rd(bdc_pkg::OFF_CACHE_QC, {QC, 16'h0000});
    rd(bdc_pkg::OFF_DISC_SECT, DSC);
    rd(bdc_pkg::OFF_ZF_SECT, ZFS);
    rd(bdc_pkg::OFF_ZF_DEALLC, 32'h0000_0001);
    rd(8'h60, 32'h0000_0000);
  endtask
  task automatic t_ro;
    wr(bdc_pkg::OFF_CAP_LO, 32'hFFFF_FFFF);
    rd(bdc_pkg::OFF_CAP_LO, CAP[31:0]);
    wr(bdc_pkg::OFF_CACHE_QC, 32'h0000_0001);
    mode(1'b0);
  endtask
  task automatic t_modern;
    logic [31:0] f [4] = '{32'h0000_1800, 32'h0000_0200, 32'h0000_0000, 32'h0000_0A00};
    logic        e [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(bdc_pkg::OFF_STATUS, 32'h0000_0000);
      wr(bdc_pkg::OFF_DRV_FEAT, f[i]);
      wr(bdc_pkg::OFF_STATUS, 32'h0000_000A);
      mode(e[i]);
      chk({16'h0, activeQueues}, f[i][12] ? {16'h0, QC} : 32'h0000_0001);
    end
    wr(bdc_pkg::OFF_CACHE_QC, 32'h0000_0000);
    mode(1'b0);
    rd(bdc_pkg::OFF_CACHE_QC, {QC, 16'h0000});
    wr(bdc_pkg::OFF_CACHE_QC, 32'h0000_0001);
    mode(1'b1);
  endtask
  task automatic t_legacy;
    wr(bdc_pkg::OFF_STATUS, 32'h0000_0000);
    wr(bdc_pkg::OFF_CTRL, 32'h0000_0001);
    wr(bdc_pkg::OFF_DRV_FEAT, 32'h0000_0A00);
    wr(bdc_pkg::OFF_STATUS, 32'h0000_0002);
    mode(1'b1);
    wr(bdc_pkg::OFF_CACHE_QC, 32'h0000_0000);
    mode(1'b0);
    wr(bdc_pkg::OFF_DRV_FEAT, 32'h0000_0200);
    mode(1'b0);
    // keep driver-ready low so the next write really sets it
    wr(bdc_pkg::OFF_STATUS, 32'h0000_0001);
    mode(1'b0);
    wr(bdc_pkg::OFF_STATUS, 32'h0000_0006);
    mode(1'b1);
    chk({31'h0, driverReady}, 32'h0000_0001);
  endtask
  task automatic t_native;
    wr(bdc_pkg::OFF_CTRL, 32'h0000_0003);
    rd(bdc_pkg::OFF_CAP_LO, bsw(CAP[63:32]));
    rd(bdc_pkg::OFF_CACHE_QC, {QC[7:0], QC[15:8], 16'h0001});
  endtask
  // a frozen enable must stall the bus and keep the mode, not lose state
  task automatic t_stall;
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    chk({30'h0, hreadyout, cacheWriteback}, 32'h0000_0001);
    @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk({30'h0, hreadyout, cacheWriteback}, 32'h0000_0003);
  endtask
  initial begin
    #20000;
    n_fail++;
    results();
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_map();
    t_ro();
    t_modern();
    t_legacy();
    t_native();
    t_stall();
    results();
  end
endmodule

// >>> src/bdc_config_space.sv
// Purpose: block device config space and feature negotiation, AHB-Lite slave
// Assumes: zero wait state slave while ce high, single word transfers, OKAY only
// Notes:   read data is sampled at the address phase edge
//
// Notes on behaviour
// - one queue unless multiqueue negotiated
// - bits 1,2,4 validate size, segment and geometry
// - read-only offer makes every write fail
// - bits 6,10 validate block size, topology
// - bit 9 announces flush support
// - bit 11 announces cache mode switching
// - bit 12 multiqueue; queue count exists then
// - bit 13 discard, reports discard limits
// - bit 14 write-zeroes, reports its limits
// - capacity and cache mode byte always present; others feature gated
// - discard and zero-fill limits in sectors
// - sector unit fixed at 512 bytes
// - cache mode field RW; 0 thru, 1 back
// - field shows mode in effect after negotiation
// - flush offered always with cache control
// - cache control without flush starts writethrough; legacy keeps its mode
// - padding bytes read as zero
// - legacy fields in guest native byte order
// - legacy status writes change mode only on driver-ready or on a zero (reset) status write
// - legacy feature writes never change mode
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module bdc_config_space #(
  parameter logic [63:0] CAPACITY_SECTORS = 64'h0000_0000_0010_0000,
  parameter logic [31:0] SIZE_MAX         = 32'h0001_0000,
  parameter logic [31:0] SEG_MAX          = 32'h0000_0080,
  parameter logic [15:0] CYLINDERS        = 16'h0400,
  parameter logic [7:0]  HEADS            = 8'h10,
  parameter logic [7:0]  SECTORS_PER_TRK  = 8'h3F,
  parameter logic [31:0] BLOCK_SIZE       = 32'h0000_0200,
  parameter logic [7:0]  PHYS_BLOCK_LOG2  = 8'h03,
  parameter logic [7:0]  ALIGN_OFFSET     = 8'h00,
  parameter logic [15:0] MIN_TRANSFER     = 16'h0001,
  parameter logic [31:0] OPT_TRANSFER     = 32'h0000_0100,
  parameter logic [15:0] QUEUE_COUNT      = 16'h0004,
  parameter logic [31:0] DISCARD_SECTORS  = 32'h0040_0000,
  parameter logic [31:0] DISCARD_SEGMENTS = 32'h0000_0001,
  parameter logic [31:0] DISCARD_ALIGN    = 32'h0000_0008,
  parameter logic [31:0] ZF_SECTORS       = 32'h0040_0000,
  parameter logic [31:0] ZF_SEGMENTS      = 32'h0000_0001,
  parameter logic [7:0]  ZF_DEALLOCATE    = 8'h01,
  parameter logic [31:0] OFFER            = bdc_pkg::FEAT_ALL,
  parameter logic        CACHE_AT_RESET   = bdc_pkg::CACHE_WRITEBACK
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [15:0]      activeQueues,
  output logic             writesFail,
  output logic             cacheWriteback,
  output logic             flushOffered,
  output logic             driverReady
);
  bdc_pkg::bdc_state_s st_q;
  bdc_pkg::bdc_state_s st_d;

  logic [31:0] devFeat;
  logic [31:0] negFeat;
  logic        swapOn;
  logic        addrTake;
  logic        wrCommit;
  logic        wrCache;
  logic        modernAccept;
  logic        legacyReady;
  logic [7:0]  newStatus;

  function automatic logic [15:0] swap16(input logic [15:0] v);
    swap16 = {v[7:0], v[15:8]};
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] v);
    swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  function automatic logic [31:0] gate(input logic en, input logic [31:0] v);
    gate = en ? v : bdc_pkg::RESET_WORD;
  endfunction

  // flush always accompanies cache control so the driver can force commits
  always_comb begin
    devFeat = OFFER & bdc_pkg::FEAT_ALL;
    if (OFFER[bdc_pkg::FEAT_CACHE_MODE_CTRL]) begin
      devFeat[bdc_pkg::FEAT_FLUSH] = 1'b1;
    end
  end

  assign negFeat = devFeat & st_q.drvFeat;
  assign swapOn  = st_q.legacy & st_q.nativeBe;

  // field word assembly, each multi-byte field swapped on its own
  function automatic logic [31:0] cfgWord(input logic [7:0] a, input logic sw);
    logic [31:0] w;
    logic [63:0] cap;
    w   = bdc_pkg::RESET_WORD;
    cap = CAPACITY_SECTORS;
    unique case (a)
      bdc_pkg::OFF_CAP_LO: begin
        w = sw ? swap32(cap[63:32]) : cap[31:0];
      end
      bdc_pkg::OFF_CAP_HI: begin
        w = sw ? swap32(cap[31:0]) : cap[63:32];
      end
      bdc_pkg::OFF_SIZE_MAX: begin
        w = gate(devFeat[bdc_pkg::FEAT_SIZE_MAX], sw ? swap32(SIZE_MAX) : SIZE_MAX);
      end
      bdc_pkg::OFF_SEG_MAX: begin
        w = gate(devFeat[bdc_pkg::FEAT_SEG_MAX], sw ? swap32(SEG_MAX) : SEG_MAX);
      end
      bdc_pkg::OFF_GEOMETRY: begin
        w = gate(devFeat[bdc_pkg::FEAT_GEOMETRY],
                 {SECTORS_PER_TRK, HEADS, sw ? swap16(CYLINDERS) : CYLINDERS});
      end
      bdc_pkg::OFF_BLK_SIZE: begin
        w = gate(devFeat[bdc_pkg::FEAT_BLK_SIZE], sw ? swap32(BLOCK_SIZE) : BLOCK_SIZE);
      end
      bdc_pkg::OFF_TOPO_A: begin
        w = gate(devFeat[bdc_pkg::FEAT_TOPOLOGY],
                 {sw ? swap16(MIN_TRANSFER) : MIN_TRANSFER, ALIGN_OFFSET,
                  PHYS_BLOCK_LOG2});
      end
      bdc_pkg::OFF_TOPO_B: begin
        w = gate(devFeat[bdc_pkg::FEAT_TOPOLOGY],
                 sw ? swap32(OPT_TRANSFER) : OPT_TRANSFER);
      end
      bdc_pkg::OFF_CACHE_QC: begin
        w[7:0]   = {7'h00, st_q.cacheWb};
        w[15:8]  = bdc_pkg::PAD_BYTE;
        if (devFeat[bdc_pkg::FEAT_MULTIQUEUE]) begin
          w[31:16] = sw ? swap16(QUEUE_COUNT) : QUEUE_COUNT;
        end
      end
      bdc_pkg::OFF_DISC_SECT: begin
        w = gate(devFeat[bdc_pkg::FEAT_DISCARD],
                 sw ? swap32(DISCARD_SECTORS) : DISCARD_SECTORS);
      end
      bdc_pkg::OFF_DISC_SEG: begin
        w = gate(devFeat[bdc_pkg::FEAT_DISCARD],
                 sw ? swap32(DISCARD_SEGMENTS) : DISCARD_SEGMENTS);
      end
      bdc_pkg::OFF_DISC_ALGN: begin
        w = gate(devFeat[bdc_pkg::FEAT_DISCARD],
                 sw ? swap32(DISCARD_ALIGN) : DISCARD_ALIGN);
      end
      bdc_pkg::OFF_ZF_SECT: begin
        w = gate(devFeat[bdc_pkg::FEAT_WRITE_ZEROES],
                 sw ? swap32(ZF_SECTORS) : ZF_SECTORS);
      end
      bdc_pkg::OFF_ZF_SEG: begin
        w = gate(devFeat[bdc_pkg::FEAT_WRITE_ZEROES],
                 sw ? swap32(ZF_SEGMENTS) : ZF_SEGMENTS);
      end
      bdc_pkg::OFF_ZF_DEALLC: begin
        w = {bdc_pkg::PAD_BYTE, bdc_pkg::PAD_BYTE, bdc_pkg::PAD_BYTE,
             devFeat[bdc_pkg::FEAT_WRITE_ZEROES] ? ZF_DEALLOCATE : bdc_pkg::PAD_BYTE};
      end
      bdc_pkg::OFF_DEV_FEAT: begin
        w = devFeat;
      end
      bdc_pkg::OFF_DRV_FEAT: begin
        w = st_q.drvFeat;
      end
      bdc_pkg::OFF_STATUS: begin
        w = {24'h00_0000, st_q.status};
      end
      bdc_pkg::OFF_CTRL: begin
        w = {30'h0000_0000, st_q.nativeBe, st_q.legacy};
      end
      default: begin
        w = bdc_pkg::RESET_WORD;
      end
    endcase
    cfgWord = w;
  endfunction

  assign addrTake = hsel & htrans[1] & hready & ce;
  assign wrCommit = st_q.wrPend & ce;
  assign newStatus = hwdata[7:0];

  // modern: field writable once cache control is negotiated and accepted;
  // legacy: the driver may write it before readiness
  assign wrCache = wrCommit & (st_q.wrAddr == bdc_pkg::OFF_CACHE_QC)
                 & negFeat[bdc_pkg::FEAT_CACHE_MODE_CTRL]
                 & (st_q.legacy | st_q.status[bdc_pkg::STAT_FEATURES_ACCEPTED]);

  assign modernAccept = wrCommit & ~st_q.legacy & (st_q.wrAddr == bdc_pkg::OFF_STATUS)
                      & newStatus[bdc_pkg::STAT_FEATURES_ACCEPTED]
                      & ~st_q.status[bdc_pkg::STAT_FEATURES_ACCEPTED];
  assign legacyReady  = wrCommit & st_q.legacy & (st_q.wrAddr == bdc_pkg::OFF_STATUS)
                      & newStatus[bdc_pkg::STAT_DRIVER_READY]
                      & ~st_q.status[bdc_pkg::STAT_DRIVER_READY]
                      & ~st_q.drvFeat[bdc_pkg::FEAT_CACHE_MODE_CTRL];

  always_comb begin
    st_d = st_q;
    if (wrCommit) begin
      st_d.wrPend = 1'b0;
      unique case (st_q.wrAddr)
        bdc_pkg::OFF_DRV_FEAT: begin
          // legacy feature writes touch only features, never the cache mode
          if (st_q.legacy | ~st_q.status[bdc_pkg::STAT_FEATURES_ACCEPTED]) begin
            st_d.drvFeat = hwdata & devFeat;
          end
        end
        bdc_pkg::OFF_STATUS: begin
          st_d.status = newStatus;
          if (newStatus == 8'h00) begin
            st_d.drvFeat = bdc_pkg::RESET_WORD;
            st_d.cacheWb = CACHE_AT_RESET;
          end
        end
        bdc_pkg::OFF_CTRL: begin
          st_d.legacy   = hwdata[bdc_pkg::CTRL_LEGACY];
          st_d.nativeBe = hwdata[bdc_pkg::CTRL_NATIVE_BE];
        end
        default: begin
          st_d.status = st_q.status;
        end
      endcase
    end
    if (wrCache) begin
      st_d.cacheWb = hwdata[0];
    end
    if (modernAccept) begin
      if (negFeat[bdc_pkg::FEAT_CACHE_MODE_CTRL]) begin
        if (~negFeat[bdc_pkg::FEAT_FLUSH]) begin
          st_d.cacheWb = bdc_pkg::CACHE_WRITETHROUGH;
        end
      end else begin
        st_d.cacheWb = negFeat[bdc_pkg::FEAT_FLUSH];
      end
    end
    if (legacyReady) begin
      st_d.cacheWb = negFeat[bdc_pkg::FEAT_FLUSH];
    end
    if (addrTake) begin
      st_d.wrPend = hwrite;
      st_d.wrAddr = {haddr[7:2], 2'b00};
      st_d.rdata  = hwrite ? bdc_pkg::RESET_WORD : cfgWord({haddr[7:2], 2'b00}, swapOn);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= '{drvFeat: 32'h0000_0000, status: 8'h00, legacy: 1'b0, nativeBe: 1'b0,
                cacheWb: CACHE_AT_RESET, wrPend: 1'b0, wrAddr: 8'h00,
                rdata: 32'h0000_0000};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // stalling on a frozen clock enable keeps transfers from being lost
  assign hreadyout      = ce;
  assign hresp          = 1'b0;
  assign hrdata         = st_q.rdata;
  assign activeQueues   = negFeat[bdc_pkg::FEAT_MULTIQUEUE] ? QUEUE_COUNT
                                                            : bdc_pkg::SINGLE_QUEUE;
  assign writesFail     = devFeat[bdc_pkg::FEAT_READ_ONLY];
  assign cacheWriteback = st_q.cacheWb;
  assign flushOffered   = devFeat[bdc_pkg::FEAT_FLUSH];
  assign driverReady    = st_q.status[bdc_pkg::STAT_DRIVER_READY];
endmodule

// >>> src/bdc_pkg.sv
// Purpose: constants and state type of the block config space
// Assumes: 32-bit AHB-Lite register access, one aligned word per register
// Notes:   config words follow the packed config layout in byte order
package bdc_pkg;
  // config space word byte addresses
  localparam logic [7:0] OFF_CAP_LO    = 8'h00;
  localparam logic [7:0] OFF_CAP_HI    = 8'h04;
  localparam logic [7:0] OFF_SIZE_MAX  = 8'h08;
  localparam logic [7:0] OFF_SEG_MAX   = 8'h0C;
  localparam logic [7:0] OFF_GEOMETRY  = 8'h10;
  localparam logic [7:0] OFF_BLK_SIZE  = 8'h14;
  localparam logic [7:0] OFF_TOPO_A    = 8'h18;
  localparam logic [7:0] OFF_TOPO_B    = 8'h1C;
  localparam logic [7:0] OFF_CACHE_QC  = 8'h20;
  localparam logic [7:0] OFF_DISC_SECT = 8'h24;
  localparam logic [7:0] OFF_DISC_SEG  = 8'h28;
  localparam logic [7:0] OFF_DISC_ALGN = 8'h2C;
  localparam logic [7:0] OFF_ZF_SECT   = 8'h30;
  localparam logic [7:0] OFF_ZF_SEG    = 8'h34;
  localparam logic [7:0] OFF_ZF_DEALLC = 8'h38;
  // transport side registers
  localparam logic [7:0] OFF_DEV_FEAT  = 8'h40;
  localparam logic [7:0] OFF_DRV_FEAT  = 8'h44;
  localparam logic [7:0] OFF_STATUS    = 8'h48;
  localparam logic [7:0] OFF_CTRL      = 8'h4C;
  // feature bit positions
  localparam int FEAT_SIZE_MAX          = 1;
  localparam int FEAT_SEG_MAX           = 2;
  localparam int FEAT_GEOMETRY          = 4;
  localparam int FEAT_READ_ONLY         = 5;
  localparam int FEAT_BLK_SIZE          = 6;
  localparam int FEAT_FLUSH             = 9;
  localparam int FEAT_TOPOLOGY          = 10;
  localparam int FEAT_CACHE_MODE_CTRL   = 11;
  localparam int FEAT_MULTIQUEUE        = 12;
  localparam int FEAT_DISCARD           = 13;
  localparam int FEAT_WRITE_ZEROES      = 14;
  localparam logic [31:0] FEAT_ALL      = 32'h0000_7E76;
  // device status bits
  localparam int STAT_DRIVER            = 1;
  localparam int STAT_DRIVER_READY      = 2;
  localparam int STAT_FEATURES_ACCEPTED = 3;
  // control register bits
  localparam int CTRL_LEGACY            = 0;
  localparam int CTRL_NATIVE_BE         = 1;
  // cache mode encodings and protocol sector size
  localparam logic       CACHE_WRITETHROUGH = 1'b0;
  localparam logic       CACHE_WRITEBACK    = 1'b1;
  localparam int         SECTOR_BYTES       = 512;
  localparam logic [15:0] SINGLE_QUEUE      = 16'h0001;
  localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
  localparam logic [7:0]  PAD_BYTE          = 8'h00;

  typedef struct packed {
    logic [31:0] drvFeat;
    logic [7:0]  status;
    logic        legacy;
    logic        nativeBe;
    logic        cacheWb;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [31:0] rdata;
  } bdc_state_s;
endpackage
